/* File: verilog/vie_map.vh */
`ifndef VIE_MAP_VH
`define VIE_MAP_VH

// ahb byte offsets
`define VIE_OFS_CMD 5'h00
`define VIE_OFS_DATA 5'h04
`define VIE_OFS_STATUS 5'h08
`define VIE_OFS_MODE 5'h0c
`define VIE_OFS_SCAN 5'h10

// instruction decode bit positions
`define VIE_OP_DDADDR 7
`define VIE_OP_CGADDR 6
`define VIE_OP_FUNC 5
`define VIE_OP_SHIFT 4
`define VIE_OP_ONOFF 3
`define VIE_OP_ENTRY 2
`define VIE_OP_HOME 1
`define VIE_OP_CLEAR 0

// status register fields
`define VIE_ST_AC_MSB 6
`define VIE_ST_BUSY 7
`define VIE_ST_CG 8

// mode register fields
`define VIE_MD_BLINK 0
`define VIE_MD_CURSOR 1
`define VIE_MD_DISPLAY 2
`define VIE_MD_SHIFTEN 3
`define VIE_MD_INC 4
`define VIE_MD_LINES 5
`define VIE_MD_WIDTH 6
`define VIE_MD_BR_LSB 7
`define VIE_MD_DSH_LSB 16

// scan register fields
`define VIE_SC_PHASE 0
`define VIE_SC_BLANK 1
`define VIE_SC_ANODE 2
`define VIE_SC_GRID_LSB 8

// reset values
`define VIE_RST_INC 1'b1
`define VIE_RST_SHIFTEN 1'b0
`define VIE_RST_WIDTH 1'b1
`define VIE_RST_LINES 1'b1
`define VIE_RST_BRIGHT 2'b00
`define VIE_RST_ONOFF 1'b0
`define VIE_SPACE_CODE 8'h20
`define VIE_DD_LAST 7'h7f

// timing
`define VIE_CLK_KHZ 20000
`define VIE_TDSP_US 200
`define VIE_TBLK_US 10
`define VIE_BLINK_HALF_MS 500
`define VIE_DSP_CYC ((`VIE_CLK_KHZ * `VIE_TDSP_US) / 1000)
`define VIE_BLK_CYC ((`VIE_CLK_KHZ * `VIE_TBLK_US) / 1000)
// half of the blink period in clocks, sized for the 24-bit timer
`define VIE_BLINK_HALF_CYC 24'd10000000
`define VIE_GRID_COUNT 24

`endif

/* File: verilog/vie_ram.v */
module vie_ram #(
   parameter AW = 7,
   parameter DW = 8
) (
   // clock
   input wire ref_clk_in,
   // write port
   input wire we_in,
   input wire [AW-1:0] waddr_in,
   input wire [DW-1:0] wdata_in,
   // read port
   input wire re_in,
   input wire [AW-1:0] raddr_in,
   output reg [DW-1:0] rdata_out
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge ref_clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   // registered read, no reset on contents
   always @(posedge ref_clk_in) begin
      if (re_in) begin
         rdata_out <= mem[raddr_in];
      end
   end

endmodule // vie_ram

/* File: verilog/vie_instruction_executor.v */
`include "vie_map.vh"

// What this block does
// - clear fills display ram, counter zero
// - clear zeroes display shift, cursor home
// - home zeroes counter and display shift
// - counter steps up or down per access
// - shift-enable write shifts display, else cursor
// - reads and char ram only move cursor
// - display, cursor, blink held independently
// - cursor blink one hertz, half duty
// - shift instruction moves cursor or both
// - width bit selects eight or four bits
// - one line drives only forty anodes
// - brightness sets anode pulse fraction
// - slot is display then blanking period
// - char address loads six-bit counter
// - char write steps counter by one
// - char address wraps at 3fh/00h
// - power-on fills spaces, counter zero
// - power-on display cursor blink off
// - power-on increment, display shift off
// - power-on eight-bit, two lines, full
module vie_instruction_executor #(
   parameter [23:0] BLINK_HALF_CYC = `VIE_BLINK_HALF_CYC
) (
   // clock and reset
   input wire ref_clk_in,
   input wire reset_in,
   // ahb-lite slave
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire [31:0] hrdata_out,
   output wire hreadyout_out,
   output wire hresp_out,
   // scanner side
   input wire [79:0] anode_pattern_in,
   output reg [79:0] anode_outputs_out,
   output reg grid_start_out,
   output reg [4:0] grid_index_out,
   output reg blank_out,
   output reg blink_lit_out,
   output reg cursor_on_out,
   output reg [6:0] cursor_pos_out,
   output reg [6:0] display_shift_out,
   output reg bus_width_sel_out
);

   localparam integer DSP_INT = `VIE_DSP_CYC;
   localparam integer SLOT_INT = `VIE_DSP_CYC + `VIE_BLK_CYC;
   localparam integer GRID_INT = `VIE_GRID_COUNT - 1;
   localparam [12:0] DSP_CYC = DSP_INT[12:0];
   localparam [12:0] SLOT_CYC = SLOT_INT[12:0];
   localparam [4:0] GRID_LAST = GRID_INT[4:0];
   localparam [23:0] BLINK_LAST = BLINK_HALF_CYC - 24'h000001;

   // settings
   reg display_on_r;
   reg cursor_on_r;
   reg blink_on_r;
   reg inc_r;
   reg shift_en_r;
   reg bus_width_sel_r;
   reg lines_r;
   reg brightness_hi_r;
   reg brightness_lo_r;
   reg [6:0] address_counter_r;
   reg cg_target_r;
   reg [6:0] shift_r;
   // clear engine
   reg fill_active_r;
   reg [6:0] fill_addr_r;
   // bus data phase
   reg dph_valid_r;
   reg dph_write_r;
   reg [4:0] dph_addr_r;
   reg [1:0] rd_cnt_r;
   reg [31:0] hrdata_r;
   reg [31:0] rd_mux;
   // scan and blink
   reg [12:0] slot_cnt_r;
   reg [23:0] blink_cnt_r;
   reg blink_phase_r;

   wire [7:0] dd_rdata;
   wire [7:0] cg_rdata;

   // step counter with wrap per target
   function [6:0] ac_step;
      input [6:0] a;
      input up;
      input cg;
      reg [5:0] low;
      begin
         low = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
         if (cg) begin
            ac_step = {1'b0, low};
         end else begin
            ac_step = up ? a + 7'h01 : a - 7'h01;
         end
      end
   endfunction

   // anode pulse length from brightness code
   function [12:0] pulse_cycles;
      input [1:0] br;
      begin
         case (br)
            2'b00: pulse_cycles = DSP_CYC;
            2'b01: pulse_cycles = DSP_CYC - {2'b00, DSP_CYC[12:2]};
            2'b10: pulse_cycles = {1'b0, DSP_CYC[12:1]};
            default: pulse_cycles = {2'b00, DSP_CYC[12:2]};
         endcase
      end
   endfunction

   // bus handshake
   wire addr_take = hsel_in & htrans_in[1] & hready_in;
   wire exec_addr = (dph_addr_r == `VIE_OFS_CMD) | (dph_addr_r == `VIE_OFS_DATA);
   // busy stalls writes rather than dropping them
   wire wr_ready = ~(fill_active_r & exec_addr);
   wire rd_ready = (rd_cnt_r == 2'd2);
   assign hreadyout_out = ~dph_valid_r | (dph_write_r ? wr_ready : rd_ready);
   assign hresp_out = 1'b0;
   assign hrdata_out = hrdata_r;

   wire done = dph_valid_r & hreadyout_out;
   wire cmd_go = done & dph_write_r & (dph_addr_r == `VIE_OFS_CMD);
   wire data_wr_go = done & dph_write_r & (dph_addr_r == `VIE_OFS_DATA);
   wire data_rd_go = done & ~dph_write_r & (dph_addr_r == `VIE_OFS_DATA);
   wire ram_re = dph_valid_r & ~dph_write_r & (dph_addr_r == `VIE_OFS_DATA) &
                 (rd_cnt_r == 2'd0) & ~fill_active_r;
   wire [7:0] cmd = hwdata_in[7:0];

   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         dph_valid_r <= 1'b0;
         dph_write_r <= 1'b0;
         dph_addr_r <= 5'h00;
      end else if (hready_in) begin
         dph_valid_r <= addr_take;
         dph_write_r <= hwrite_in;
         dph_addr_r <= {haddr_in[4:2], 2'b00};
      end
   end

   // reads wait two cycles: ram read, then capture
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         rd_cnt_r <= 2'd0;
         hrdata_r <= 32'h00000000;
      end else if (done) begin
         rd_cnt_r <= 2'd0;
      end else if (dph_valid_r & ~dph_write_r & ~fill_active_r) begin
         rd_cnt_r <= rd_cnt_r + 2'd1;
         if (rd_cnt_r == 2'd1) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   always @* begin
      rd_mux = 32'h00000000;
      if (dph_addr_r == `VIE_OFS_DATA) begin
         rd_mux[7:0] = cg_target_r ? cg_rdata : dd_rdata;
      end else if (dph_addr_r == `VIE_OFS_STATUS) begin
         rd_mux[`VIE_ST_AC_MSB:0] = address_counter_r;
         rd_mux[`VIE_ST_BUSY] = fill_active_r;
         rd_mux[`VIE_ST_CG] = cg_target_r;
      end else if (dph_addr_r == `VIE_OFS_MODE) begin
         rd_mux[`VIE_MD_BLINK] = blink_on_r;
         rd_mux[`VIE_MD_CURSOR] = cursor_on_r;
         rd_mux[`VIE_MD_DISPLAY] = display_on_r;
         rd_mux[`VIE_MD_SHIFTEN] = shift_en_r;
         rd_mux[`VIE_MD_INC] = inc_r;
         rd_mux[`VIE_MD_LINES] = lines_r;
         rd_mux[`VIE_MD_WIDTH] = bus_width_sel_r;
         rd_mux[`VIE_MD_BR_LSB+1] = brightness_hi_r;
         rd_mux[`VIE_MD_BR_LSB] = brightness_lo_r;
         rd_mux[`VIE_MD_DSH_LSB+6:`VIE_MD_DSH_LSB] = shift_r;
      end else if (dph_addr_r == `VIE_OFS_SCAN) begin
         rd_mux[`VIE_SC_PHASE] = blink_phase_r;
         rd_mux[`VIE_SC_BLANK] = blank_out;
         rd_mux[`VIE_SC_ANODE] = (slot_cnt_r < pulse_cycles({brightness_hi_r, brightness_lo_r}));
         rd_mux[`VIE_SC_GRID_LSB+4:`VIE_SC_GRID_LSB] = grid_index_out;
      end
   end

   // instruction execution and shared counter
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         display_on_r <= `VIE_RST_ONOFF;
         cursor_on_r <= `VIE_RST_ONOFF;
         blink_on_r <= `VIE_RST_ONOFF;
         inc_r <= `VIE_RST_INC;
         shift_en_r <= `VIE_RST_SHIFTEN;
         bus_width_sel_r <= `VIE_RST_WIDTH;
         lines_r <= `VIE_RST_LINES;
         {brightness_hi_r, brightness_lo_r} <= `VIE_RST_BRIGHT;
         address_counter_r <= 7'h00;
         cg_target_r <= 1'b0;
         shift_r <= 7'h00;
         fill_active_r <= 1'b1;
         fill_addr_r <= 7'h00;
      end else begin
         if (fill_active_r) begin
            fill_addr_r <= fill_addr_r + 7'h01;
            if (fill_addr_r == `VIE_DD_LAST) begin
               fill_active_r <= 1'b0;
            end
         end
         if (cmd_go) begin
            if (cmd[`VIE_OP_DDADDR]) begin
               address_counter_r <= cmd[6:0];
               cg_target_r <= 1'b0;
            end else if (cmd[`VIE_OP_CGADDR]) begin
               address_counter_r <= {1'b0, cmd[5:0]};
               cg_target_r <= 1'b1;
            end else if (cmd[`VIE_OP_FUNC]) begin
               bus_width_sel_r <= cmd[4];
               lines_r <= cmd[3];
               brightness_hi_r <= cmd[1];
               brightness_lo_r <= cmd[0];
            end else if (cmd[`VIE_OP_SHIFT]) begin
               address_counter_r <= ac_step(address_counter_r, cmd[2], cg_target_r);
               if (cmd[3]) begin
                  shift_r <= cmd[2] ? shift_r + 7'h01 : shift_r - 7'h01;
               end
            end else if (cmd[`VIE_OP_ONOFF]) begin
               display_on_r <= cmd[2];
               cursor_on_r <= cmd[1];
               blink_on_r <= cmd[0];
            end else if (cmd[`VIE_OP_ENTRY]) begin
               inc_r <= cmd[1];
               shift_en_r <= cmd[0];
            end else if (cmd[`VIE_OP_HOME]) begin
               address_counter_r <= 7'h00;
               cg_target_r <= 1'b0;
               shift_r <= 7'h00;
            end else if (cmd[`VIE_OP_CLEAR]) begin
               fill_active_r <= 1'b1;
               fill_addr_r <= 7'h00;
               address_counter_r <= 7'h00;
               cg_target_r <= 1'b0;
               shift_r <= 7'h00;
            end
         end
         if (data_wr_go | data_rd_go) begin
            address_counter_r <= ac_step(address_counter_r, inc_r, cg_target_r);
         end
         if (data_wr_go & ~cg_target_r & shift_en_r) begin
            shift_r <= inc_r ? shift_r - 7'h01 : shift_r + 7'h01;
         end
      end
   end

   // display ram: fill has the write port while busy
   vie_ram #(.AW(7), .DW(8)) u_display_ram (
      .ref_clk_in(ref_clk_in),
      .we_in(fill_active_r | (data_wr_go & ~cg_target_r)),
      .waddr_in(fill_active_r ? fill_addr_r : address_counter_r),
      .wdata_in(fill_active_r ? `VIE_SPACE_CODE : hwdata_in[7:0]),
      .re_in(ram_re & ~cg_target_r),
      .raddr_in(address_counter_r),
      .rdata_out(dd_rdata)
   );

   vie_ram #(.AW(6), .DW(8)) u_char_gen_ram (
      .ref_clk_in(ref_clk_in),
      .we_in(data_wr_go & cg_target_r),
      .waddr_in(address_counter_r[5:0]),
      .wdata_in(hwdata_in[7:0]),
      .re_in(ram_re & cg_target_r),
      .raddr_in(address_counter_r[5:0]),
      .rdata_out(cg_rdata)
   );

   // grid slot timing
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         slot_cnt_r <= 13'h0000;
         grid_index_out <= 5'h00;
         grid_start_out <= 1'b0;
         blank_out <= 1'b0;
      end else begin
         grid_start_out <= (slot_cnt_r == SLOT_CYC - 13'h0001);
         if (slot_cnt_r == SLOT_CYC - 13'h0001) begin
            slot_cnt_r <= 13'h0000;
            grid_index_out <= (grid_index_out == GRID_LAST) ? 5'h00 :
                              grid_index_out + 5'h01;
         end else begin
            slot_cnt_r <= slot_cnt_r + 13'h0001;
         end
         blank_out <= (slot_cnt_r >= DSP_CYC - 13'h0001) & (slot_cnt_r != SLOT_CYC - 13'h0001);
      end
   end

   // blink timer free-runs so phase is stable across toggles
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         blink_cnt_r <= 24'h000000;
         blink_phase_r <= 1'b0;
      end else if (blink_cnt_r == BLINK_LAST) begin
         blink_cnt_r <= 24'h000000;
         blink_phase_r <= ~blink_phase_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 24'h000001;
      end
   end

   // anode gating, registered outputs
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         anode_outputs_out <= 80'h0;
         blink_lit_out <= 1'b0;
         cursor_on_out <= 1'b0;
         cursor_pos_out <= 7'h00;
         display_shift_out <= 7'h00;
         bus_width_sel_out <= `VIE_RST_WIDTH;
      end else begin
         if (display_on_r & (slot_cnt_r < pulse_cycles({brightness_hi_r, brightness_lo_r}))) begin
            anode_outputs_out <= anode_pattern_in &
                                 {{40{lines_r}}, 40'hff_ffff_ffff};
         end else begin
            anode_outputs_out <= 80'h0;
         end
         blink_lit_out <= display_on_r & blink_on_r & blink_phase_r;
         cursor_on_out <= display_on_r & cursor_on_r;
         cursor_pos_out <= address_counter_r;
         display_shift_out <= shift_r;
         bus_width_sel_out <= bus_width_sel_r;
      end
   end

endmodule // vie_instruction_executor

/* File: sim/vie_exec_properties.sv */
module vie_exec_properties #(
   parameter [23:0] BLINK_HALF_CYC = 24'd20
) (
   // clock and reset
   input wire ref_clk_in,
   input wire reset_in,
   // bus
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire hready_in,
   input wire hreadyout_out,
   input wire hresp_out,
   // scanner side
   input wire [79:0] anode_outputs_out,
   input wire grid_start_out,
   input wire [4:0] grid_index_out,
   input wire blank_out,
   input wire blink_lit_out,
   input wire cursor_on_out,
   input wire [6:0] cursor_pos_out,
   input wire [6:0] display_shift_out,
   input wire bus_width_sel_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   reg [12:0] blank_len_r;
   reg [12:0] disp_len_r;
   reg [23:0] lit_len_r;
   reg seen_r;
   // run lengths, so long counts need no long repetition
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         blank_len_r <= 13'h0;
         disp_len_r <= 13'h0;
         lit_len_r <= 24'h0;
         seen_r <= 1'b0;
      end else begin
         blank_len_r <= blank_out ? blank_len_r + 13'h1 : 13'h0;
         disp_len_r <= grid_start_out ? 13'h1 : disp_len_r + {12'h0, !blank_out};
         lit_len_r <= blink_lit_out ? lit_len_r + 24'h1 : 24'h0;
         seen_r <= seen_r | grid_start_out;
      end
   end
   sequence rd_ap;
      hsel_in && htrans_in[1] && hready_in && !hwrite_in;
   endsequence
   sequence wr_reg_ap;
      hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in[4:2] >= 3'h2;
   endsequence
   a_resp_always_okay: assert property (hresp_out == 1'b0)
      else $error("error response seen");
   a_reset_defaults: assert property ($fell(reset_in) |-> bus_width_sel_out &&
      cursor_pos_out == 7'h00 && display_shift_out == 7'h00 && !cursor_on_out && !blink_lit_out)
      else $error("wrong state after reset");
   a_read_two_waits: assert property (rd_ap |=> !hreadyout_out [*2])
      else $error("read answered too soon");
   a_reg_write_nowait: assert property (wr_reg_ap |=> hreadyout_out)
      else $error("register write stalled");
   a_start_in_display: assert property (grid_start_out |-> !blank_out)
      else $error("slot starts in blanking");
   a_grid_step: assert property (grid_start_out |-> grid_index_out ==
      (($past(grid_index_out) == 5'd23) ? 5'd0 : $past(grid_index_out) + 5'd1))
      else $error("grid index step wrong");
   a_grid_hold: assert property (!grid_start_out |-> $stable(grid_index_out))
      else $error("grid index moved mid slot");
   a_blank_length: assert property ($fell(blank_out) |-> blank_len_r == 13'd200)
      else $error("blanking length wrong");
   a_display_length: assert property (seen_r && $rose(blank_out) |-> disp_len_r == 13'd4000)
      else $error("display period length wrong");
   a_blink_half_max: assert property (lit_len_r <= BLINK_HALF_CYC)
      else $error("blink half too long");
   a_anode_dark_blank: assert property (blank_out && $past(blank_out) && $past(blank_out, 2)
      |-> anode_outputs_out == 80'h0)
      else $error("anodes lit in blanking");
endmodule // vie_exec_properties

/* File: sim/vie_scan_source.sv */
module vie_scan_source (
   // pattern to the block
   output wire [79:0] pattern_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // all dots lit, so gating alone shapes the anodes
   assign pattern_out = {80{1'b1}};
endmodule // vie_scan_source

/* File: sim/testbench.sv */
`include "vie_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   reg clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   reg [31:0] haddr = 32'h0, hwdata = 32'h0, rv;
   reg [1:0] htrans = 2'h0;
   wire [31:0] hrdata;
   wire [79:0] pat, anodes;
   wire [6:0] cpos, dsh;
   wire hrdy, blit, con, bw;
   integer fail_count = 0, samples_checked = 0, k, i;
   vie_scan_source src_u (.pattern_out(pat));
   vie_instruction_executor #(.BLINK_HALF_CYC(24'd20)) dut_u (.ref_clk_in(clk), .reset_in(rst),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(), .anode_pattern_in(pat), .anode_outputs_out(anodes), .grid_start_out(),
      .grid_index_out(), .blank_out(), .blink_lit_out(blit), .cursor_on_out(con),
      .cursor_pos_out(cpos), .display_shift_out(dsh), .bus_width_sel_out(bw));
   initial begin
      forever #25 clk = ~clk;
   end
   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // one single word transfer; waits end on hready or the bound
   task bus(input [4:0] a, input w, input [31:0] d);
      begin
         k = 0;
         @(posedge clk);
         hsel <= 1'b1;
         haddr <= {27'h0, a};
         htrans <= 2'h2;
         hwrite <= w;
         do begin
            @(posedge clk);
            k = k + 1;
         end while (hrdy !== 1'b1 && k < 900);
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         do begin
            @(posedge clk);
            k = k + 1;
         end while (hrdy !== 1'b1 && k < 900);
         rv = hrdata;
         if (k >= 900) begin
            fail_count = fail_count + 1;
            end_sim;
         end
      end
   endtask
   task cmd(input [7:0] c); bus(`VIE_OFS_CMD, 1'b1, {24'h0, c}); endtask
   task rd_chk(input [4:0] a, input [31:0] e); begin bus(a, 1'b0, 32'h0); chk(rv, e); end endtask
   task t_reset;
      begin
         rd_chk(`VIE_OFS_STATUS, 32'h0);
         rd_chk(`VIE_OFS_MODE, 32'h70);
         chk(bw, 1);
      end
   endtask
   task t_func;
      begin
         cmd(8'h39);
         rd_chk(`VIE_OFS_MODE, 32'hf0);
         cmd(8'h22);
         rd_chk(`VIE_OFS_MODE, 32'h110);
         chk(bw, 0);
         cmd(8'h0c);
         i = 0;
         while (anodes[0] !== 1'b1 && i < 4300) begin
            @(posedge clk);
            i = i + 1;
         end
         chk(anodes[0], 1);
         chk(|anodes[79:40], 0);
         cmd(8'h38);
         // registered copy lands two edges after the command
         repeat (2) @(negedge clk);
         chk(bw, 1);
      end
   endtask
   task t_onoff;
      begin
         cmd(8'h0f);
         rd_chk(`VIE_OFS_MODE, 32'h77);
         chk(con, 1);
         cmd(8'h0a);
         rd_chk(`VIE_OFS_MODE, 32'h72);
         chk(con, 0);
         cmd(8'h0d);
         repeat (5) @(posedge clk);
         i = 0;
         repeat (200) begin @(posedge clk); i = i + blit; end
         chk(i, 100);
      end
   endtask
   task t_entry;
      begin
         cmd(8'h85);
         cmd(8'h06);
         bus(`VIE_OFS_DATA, 1'b1, 32'h41);
         rd_chk(`VIE_OFS_STATUS, 32'h6);
         cmd(8'h07);
         bus(`VIE_OFS_DATA, 1'b1, 32'h42);
         rd_chk(`VIE_OFS_MODE, 32'h7f007d);
         // shift enabled on purpose: reads must still only move the cursor
         cmd(8'h05);
         rd_chk(`VIE_OFS_DATA, 32'h20);
         rd_chk(`VIE_OFS_DATA, 32'h42);
         rd_chk(`VIE_OFS_STATUS, 32'h5);
         rd_chk(`VIE_OFS_MODE, 32'h7f006d);
         cmd(8'h04);
         cmd(8'h02);
         rd_chk(`VIE_OFS_STATUS, 32'h0);
         rd_chk(`VIE_OFS_MODE, 32'h65);
      end
   endtask
   task t_shift;
      reg [31:0] codes, counts, shifts;
      begin
         codes = 32'h141c1810; counts = 32'h01020100; shifts = 32'h00010000;
         for (i = 3; i >= 0; i = i - 1) begin
            cmd(codes[i*8 +: 8]);
            rd_chk(`VIE_OFS_STATUS, {24'h0, counts[i*8 +: 8]});
            rd_chk(`VIE_OFS_MODE, {8'h0, shifts[i*8 +: 8], 16'h65});
         end
      end
   endtask
   task t_char_gen_ram;
      begin
         cmd(8'h06); cmd(8'h7f);
         bus(`VIE_OFS_DATA, 1'b1, 32'h11);
         rd_chk(`VIE_OFS_STATUS, 32'h100);
         cmd(8'h04);
         bus(`VIE_OFS_DATA, 1'b1, 32'h22);
         rd_chk(`VIE_OFS_STATUS, 32'h13f);
         rd_chk(`VIE_OFS_DATA, 32'h11);
      end
   endtask
   task t_clear;
      begin
         cmd(8'h1c); cmd(8'h01);
         rd_chk(`VIE_OFS_STATUS, 32'h0);
         rd_chk(`VIE_OFS_MODE, 32'h65);
         cmd(8'h85);
         rd_chk(`VIE_OFS_DATA, 32'h20);
         bus(5'h1c, 1'b1, 32'hffffffff);
         rd_chk(5'h1c, 32'h0);
      end
   endtask
   task t_bright;
      begin
         cmd(8'h0c);
         for (i = 0; i < 4; i = i + 1) begin
            cmd(8'h38 | i[7:0]);
            // first sample still carries the old brightness
            @(posedge clk);
            k = 0;
            repeat (4200) begin
               @(posedge clk);
               k = k + anodes[0];
            end
            chk(k, 4000 - 1000 * i);
         end
         bus(`VIE_OFS_SCAN, 1'b0, 32'h0);
         chk(rv & 32'hffffe0f8, 32'h0);
         chk(rv[12:8] < 5'd24, 1);
         chk(rv[1] & rv[2], 0);
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_func;
      t_onoff;
      t_entry;
      t_shift;
      t_char_gen_ram;
      t_clear;
      t_bright;
      end_sim;
   end
endmodule // testbench
bind vie_instruction_executor vie_exec_properties #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) chk_u (.*);
